/* File: design/vbfi_pkg.sv */
// constants and carrier types for the vector base and fast interrupt slice
package vbfi_pkg;

   // ****************************************
   // bus and data widths
   // ****************************************
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned REG_W   = 16;
   localparam int unsigned ADR_W   = 6;
   localparam int unsigned IDX_W   = 4;
   localparam int unsigned VA_W    = 21;
   localparam int unsigned VEC_W   = 6;
   localparam int unsigned CODE_W  = 2;
   localparam int unsigned RANK_W  = 4;

   // ****************************************
   // register indices (byte address is four times the index)
   // ****************************************
   localparam logic [IDX_W-1:0] IDX_PRIO  = 4'h6;
   localparam logic [IDX_W-1:0] IDX_BASE  = 4'h7;
   localparam logic [IDX_W-1:0] IDX_SEL0  = 4'h8;
   localparam logic [IDX_W-1:0] IDX_TLO0  = 4'h9;
   localparam logic [IDX_W-1:0] IDX_THI0  = 4'hA;
   localparam logic [IDX_W-1:0] IDX_SEL1  = 4'hB;
   localparam logic [IDX_W-1:0] IDX_TLO1  = 4'hC;
   localparam logic [IDX_W-1:0] IDX_THI1  = 4'hD;
   localparam logic [IDX_W-1:0] IDX_STAT  = 4'hE;
   localparam logic [IDX_W-1:0] IDX_MASK  = 4'hF;

   // ****************************************
   // field layouts
   // ****************************************
   localparam int unsigned ADC_PRIO_LSB  = 2;
   localparam int unsigned PIT2_PRIO_LSB = 0;
   localparam int unsigned PRIO_W        = 4;
   localparam int unsigned BASE_W        = 14;
   localparam int unsigned THI_W         = 5;
   localparam int unsigned LOW_W         = 7;
   localparam int unsigned ST_FI0        = 0;
   localparam int unsigned ST_FI1        = 1;
   localparam int unsigned ST_VEC        = 2;
   localparam int unsigned ST_W          = 3;

   // ****************************************
   // codes, reset values and timing
   // ****************************************
   localparam logic [CODE_W-1:0] PRIO_OFF     = 2'h0;
   localparam logic [CODE_W-1:0] PRIO_L2      = 2'h3;
   localparam logic [REG_W-1:0]  BASE_RST_LO  = 16'h0000;
   localparam logic [REG_W-1:0]  BASE_RST_HI  = 16'h0080;
   localparam logic [1:0]        HOLD_EDGES   = 2'h2;

   // one interrupt candidate entering arbitration
   typedef struct packed {
      logic              req;
      logic [CODE_W-1:0] code;
      logic [VEC_W-1:0]  vec;
   } vbfi_cand_t;

endpackage : vbfi_pkg

/* File: design/vbfi_top.sv */
// vector base, priority fields and two fast interrupt channels behind classic wishbone
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps

// Overview of operation
// - adc done priority in bits 3..2
// - timer2 priority in bits 1..0, max level 2
// - priority fields reset to disabled code
// - base bits 13..0 form vector upper bits
// - low seven bits from winning vector number
// - base reset value chosen by variant
// - select0 bits 5..0 pick fast irq 0
// - select1 bits 5..0 pick fast irq 1
// - fast irq presents its direct target address
// - fast source beats other level 2 requests
// - fast irq 0 wins over fast irq 1
// - fast0 target is high5 then low16
// - fast1 target assembled the same way
// - reset returns all registers to defaults
// - reset vector held until second edge
module vbfi_top
   import vbfi_pkg::*;
#(
   parameter logic [VEC_W-1:0] ADC_A_VEC   = 6'h10,
   parameter logic [VEC_W-1:0] PIT2_VEC    = 6'h11,
   parameter bit               BASE_HI_VAR = 1'b1
)(
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [DATA_W-1:0] wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   output logic      [DATA_W-1:0] wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              ext_req_i,
   input  wire logic [CODE_W-1:0] ext_prio_i,
   input  wire logic [VEC_W-1:0]  ext_vec_i,
   input  wire logic              adc_a_done_irq_i,
   input  wire logic              interval_timer2_irq_i,
   input  wire logic              core_ack_i,
   output logic      [VA_W-1:0]   vector_address_out_o,
   output logic                   core_req_o,
   output logic                   irq_o
);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (ADC_A_VEC == PIT2_VEC) begin : g_bad_vec
      $error("adc and timer2 vector numbers must differ");
   end

   localparam logic [REG_W-1:0] BASE_RST = BASE_HI_VAR ? BASE_RST_HI : BASE_RST_LO;
   localparam logic [VA_W-1:0]  RST_VEC  = {BASE_RST[BASE_W-1:0], 7'h00};

   // ****************************************
   // helper functions
   // ****************************************
   // byte-lane merge of a 16 bit register
   function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] dat,
                                                 input logic [3:0] sel);
      logic [REG_W-1:0] res;
      res = old_v;
      if (sel[0]) begin
         res[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = dat[15:8];
      end
      return res;
   endfunction : merge16

   // rank: code, then fast0 bonus, then fast1 bonus; zero means no request
   function automatic logic [RANK_W-1:0] rank_of(input vbfi_cand_t c,
                                                 input logic [VEC_W-1:0] s0,
                                                 input logic [VEC_W-1:0] s1);
      logic f0;
      logic f1;
      f0 = (c.code == PRIO_L2) && (c.vec == s0);
      f1 = (c.code == PRIO_L2) && (c.vec == s1) && !f0;
      if (!c.req || c.code == PRIO_OFF) begin
         return '0;
      end
      return {c.code, f0, f1};
   endfunction : rank_of

   // ties on rank go to the lower vector number, as in the table order
   function automatic logic beats(input logic [RANK_W-1:0] ra, input logic [VEC_W-1:0] va,
                                  input logic [RANK_W-1:0] rb, input logic [VEC_W-1:0] vb);
      return (ra > rb) || ((ra == rb) && (ra != '0) && (va < vb));
   endfunction : beats

   // ****************************************
   // registers
   // ****************************************
   logic [PRIO_W-1:0] prio_r,  prio_nxt;
   logic [BASE_W-1:0] base_r,  base_nxt;
   logic [VEC_W-1:0]  sel0_r,  sel0_nxt;
   logic [VEC_W-1:0]  sel1_r,  sel1_nxt;
   logic [REG_W-1:0]  tlo0_r,  tlo0_nxt;
   logic [REG_W-1:0]  tlo1_r,  tlo1_nxt;
   logic [THI_W-1:0]  thi0_r,  thi0_nxt;
   logic [THI_W-1:0]  thi1_r,  thi1_nxt;
   logic [ST_W-1:0]   stat_r,  stat_nxt;
   logic [ST_W-1:0]   mask_r,  mask_nxt;
   logic              ack_r,   ack_nxt;
   logic [DATA_W-1:0] rdat_r,  rdat_nxt;
   logic [1:0]        hold_r,  hold_nxt;
   logic [VA_W-1:0]   va_r,    va_nxt;
   logic              req_r,   req_nxt;
   logic              fast0_r, fast0_nxt;
   logic              fast1_r, fast1_nxt;
   logic              irq_r,   irq_nxt;

   // ****************************************
   // wishbone decode
   // ****************************************
   // ack_r gates the decode so a strobe held into the ack cycle is taken once
   wire logic             bus_go  = wb_cyc_i && wb_stb_i && !ack_r;
   wire logic             bus_wr  = bus_go && wb_we_i;
   wire logic [IDX_W-1:0] idx     = wb_adr_i[ADR_W-1:2];
   wire logic             hit_prio = idx == IDX_PRIO;
   wire logic             hit_base = idx == IDX_BASE;
   wire logic             hit_sel0 = idx == IDX_SEL0;
   wire logic             hit_tlo0 = idx == IDX_TLO0;
   wire logic             hit_thi0 = idx == IDX_THI0;
   wire logic             hit_sel1 = idx == IDX_SEL1;
   wire logic             hit_tlo1 = idx == IDX_TLO1;
   wire logic             hit_thi1 = idx == IDX_THI1;
   wire logic             hit_stat = idx == IDX_STAT;
   wire logic             hit_mask = idx == IDX_MASK;

   // unmapped words answer with ack and zero data, writes there are dropped
   wire logic [REG_W-1:0] rd_word =
      hit_prio ? REG_W'(prio_r) :
      hit_base ? REG_W'(base_r) :
      hit_sel0 ? REG_W'(sel0_r) :
      hit_tlo0 ? tlo0_r :
      hit_thi0 ? REG_W'(thi0_r) :
      hit_sel1 ? REG_W'(sel1_r) :
      hit_tlo1 ? tlo1_r :
      hit_thi1 ? REG_W'(thi1_r) :
      hit_stat ? REG_W'(stat_r) :
      hit_mask ? REG_W'(mask_r) : '0;

   assign ack_nxt  = bus_go;
   assign rdat_nxt = (bus_go && !wb_we_i) ? DATA_W'(rd_word) : '0;

   // reserved bits are not stored and read back as zero
   wire logic [REG_W-1:0] wr_prio = merge16(REG_W'(prio_r), wb_dat_i, wb_sel_i);
   wire logic [REG_W-1:0] wr_base = merge16(REG_W'(base_r), wb_dat_i, wb_sel_i);
   wire logic [REG_W-1:0] wr_sel0 = merge16(REG_W'(sel0_r), wb_dat_i, wb_sel_i);
   wire logic [REG_W-1:0] wr_sel1 = merge16(REG_W'(sel1_r), wb_dat_i, wb_sel_i);
   wire logic [REG_W-1:0] wr_thi0 = merge16(REG_W'(thi0_r), wb_dat_i, wb_sel_i);
   wire logic [REG_W-1:0] wr_thi1 = merge16(REG_W'(thi1_r), wb_dat_i, wb_sel_i);
   wire logic [REG_W-1:0] wr_mask = merge16(REG_W'(mask_r), wb_dat_i, wb_sel_i);
   wire logic [REG_W-1:0] wr_stat = merge16('0, wb_dat_i, wb_sel_i);

   assign prio_nxt = (bus_wr && hit_prio) ? wr_prio[PRIO_W-1:0] : prio_r;
   // base register holds the upper vector bits
   assign base_nxt = (bus_wr && hit_base) ? wr_base[BASE_W-1:0] : base_r;
   assign sel0_nxt = (bus_wr && hit_sel0) ? wr_sel0[VEC_W-1:0] : sel0_r;
   assign sel1_nxt = (bus_wr && hit_sel1) ? wr_sel1[VEC_W-1:0] : sel1_r;
   assign tlo0_nxt = (bus_wr && hit_tlo0) ? merge16(tlo0_r, wb_dat_i, wb_sel_i) : tlo0_r;
   assign tlo1_nxt = (bus_wr && hit_tlo1) ? merge16(tlo1_r, wb_dat_i, wb_sel_i) : tlo1_r;
   assign thi0_nxt = (bus_wr && hit_thi0) ? wr_thi0[THI_W-1:0] : thi0_r;
   assign thi1_nxt = (bus_wr && hit_thi1) ? wr_thi1[THI_W-1:0] : thi1_r;
   assign mask_nxt = (bus_wr && hit_mask) ? wr_mask[ST_W-1:0] : mask_r;

   // ****************************************
   // arbitration
   // ****************************************
   vbfi_cand_t cand_ext;
   vbfi_cand_t cand_adc;
   vbfi_cand_t cand_pit;
   assign cand_ext = '{req: ext_req_i, code: ext_prio_i, vec: ext_vec_i};
   assign cand_adc = '{req: adc_a_done_irq_i, code: prio_r[ADC_PRIO_LSB +: CODE_W], vec: ADC_A_VEC};
   assign cand_pit = '{req: interval_timer2_irq_i, code: prio_r[PIT2_PRIO_LSB +: CODE_W], vec: PIT2_VEC};

   // a disabled code ranks zero and never wins
   wire logic [RANK_W-1:0] rk_ext = rank_of(cand_ext, sel0_r, sel1_r);
   wire logic [RANK_W-1:0] rk_adc = rank_of(cand_adc, sel0_r, sel1_r);
   wire logic [RANK_W-1:0] rk_pit = rank_of(cand_pit, sel0_r, sel1_r);

   // fast bonus sits above every plain level 2 rank
   // fast0 bonus bit outranks fast1 bonus bit
   wire logic             a_wins  = beats(rk_adc, ADC_A_VEC, rk_ext, ext_vec_i);
   wire logic [RANK_W-1:0] rk_ab  = a_wins ? rk_adc : rk_ext;
   wire logic [VEC_W-1:0]  vec_ab = a_wins ? ADC_A_VEC : ext_vec_i;
   wire logic             p_wins  = beats(rk_pit, PIT2_VEC, rk_ab, vec_ab);
   wire logic [RANK_W-1:0] win_rk = p_wins ? rk_pit : rk_ab;
   wire logic [VEC_W-1:0]  win_vec = p_wins ? PIT2_VEC : vec_ab;
   wire logic             win_ok  = win_rk != '0;
   wire logic             win_f0  = win_rk[1];
   wire logic             win_f1  = win_rk[0];

   wire logic [VA_W-1:0] tgt0 = {thi0_r, tlo0_r};
   wire logic [VA_W-1:0] tgt1 = {thi1_r, tlo1_r};
   // jump table entry is vector number times two
   wire logic [VA_W-1:0] tbl  = {base_r, win_vec, 1'b0};

   // saturating counter, idle once the hold is over
   // count release edges, hold the reset vector through the first and drop it at the second
   assign hold_nxt = (hold_r == HOLD_EDGES) ? hold_r : hold_r + 2'h1;
   wire logic holding = hold_nxt != HOLD_EDGES;

   // fast channel bypasses the jump table
   // registers feed the vector flop, so a write shows one cycle later
   assign va_nxt    = holding ? RST_VEC :
                      (win_ok && win_f0) ? tgt0 :
                      (win_ok && win_f1) ? tgt1 :
                      win_ok ? tbl : {base_r, 7'h00};
   assign req_nxt   = !holding && win_ok;
   assign fast0_nxt = !holding && win_ok && win_f0;
   assign fast1_nxt = !holding && win_ok && win_f1;

   // ****************************************
   // event status, mask and interrupt line
   // ****************************************
   wire logic          taken  = req_r && core_ack_i;
   wire logic [ST_W-1:0] ev   = {taken && !fast0_r && !fast1_r, taken && fast1_r, taken && fast0_r};
   wire logic [ST_W-1:0] clr  = (bus_wr && hit_stat) ? wr_stat[ST_W-1:0] : '0;
   // a new event in the clearing cycle survives the write-one clear
   assign stat_nxt = (stat_r & ~clr) | ev;
   // registered so the pin comes from a flop, one cycle behind status
   assign irq_nxt  = |(stat_r & mask_r);

   // ****************************************
   // flip-flops
   // ****************************************
   // every register returns to its default
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prio_r <= '0;
         base_r <= BASE_RST[BASE_W-1:0];
         sel0_r <= '0;
         sel1_r <= '0;
         tlo0_r <= '0;
         tlo1_r <= '0;
         thi0_r <= '0;
         thi1_r <= '0;
         stat_r <= '0;
         mask_r <= '0;
      end else begin
         prio_r <= prio_nxt;
         base_r <= base_nxt;
         sel0_r <= sel0_nxt;
         sel1_r <= sel1_nxt;
         tlo0_r <= tlo0_nxt;
         tlo1_r <= tlo1_nxt;
         thi0_r <= thi0_nxt;
         thi1_r <= thi1_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
      end
   end

   // reset vector shown while reset is low
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_r   <= 1'b0;
         rdat_r  <= '0;
         hold_r  <= '0;
         va_r    <= RST_VEC;
         req_r   <= 1'b0;
         fast0_r <= 1'b0;
         fast1_r <= 1'b0;
         irq_r   <= 1'b0;
      end else begin
         ack_r   <= ack_nxt;
         rdat_r  <= rdat_nxt;
         hold_r  <= hold_nxt;
         va_r    <= va_nxt;
         req_r   <= req_nxt;
         fast0_r <= fast0_nxt;
         fast1_r <= fast1_nxt;
         irq_r   <= irq_nxt;
      end
   end

   assign wb_ack_o             = ack_r;
   assign wb_dat_o             = rdat_r;
   assign vector_address_out_o = va_r;
   assign core_req_o           = req_r;
   assign irq_o                = irq_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   a_table_addr: assert property (win_ok && !win_f0 && !win_f1 && !holding |=>
      vector_address_out_o == {$past(base_r), $past(win_vec), 1'b0})
      else $error("table vector does not join base and vector number");

   a_low_bits: assert property (core_req_o && !fast0_r && !fast1_r |->
      vector_address_out_o[LOW_W-1:1] == $past(win_vec) && !vector_address_out_o[0])
      else $error("low vector bits do not follow the winner");

   a_fast0_addr: assert property (win_ok && win_f0 && !holding |=>
      vector_address_out_o == {$past(thi0_r), $past(tlo0_r)} && fast0_r)
      else $error("fast irq 0 target not presented");

   a_fast1_addr: assert property (win_ok && win_f1 && !holding |=>
      vector_address_out_o == {$past(thi1_r), $past(tlo1_r)} && fast1_r)
      else $error("fast irq 1 target not presented");

   a_fast_order: assert property (rk_ext[1] || rk_adc[1] || rk_pit[1] |->
      win_f0 && !win_f1)
      else $error("fast irq 0 lost arbitration");

   a_fast_beats: assert property ((rk_ext[0] || rk_adc[0] || rk_pit[0]) && !rk_ext[1] && !rk_adc[1]
      && !rk_pit[1] |-> win_f1)
      else $error("fast irq 1 lost to a plain request");

   a_adc_off: assert property (prio_r[ADC_PRIO_LSB +: CODE_W] == PRIO_OFF && !ext_req_i
      && !(interval_timer2_irq_i && prio_r[PIT2_PRIO_LSB +: CODE_W] != PRIO_OFF) |-> !win_ok)
      else $error("disabled adc request won");

   a_pit_level: assert property (interval_timer2_irq_i && !adc_a_done_irq_i && !ext_req_i
      && prio_r[PIT2_PRIO_LSB +: CODE_W] != PRIO_OFF |-> win_ok && win_vec == PIT2_VEC)
      else $error("enabled timer2 request did not win alone");

   a_reset_hold: assert property ($rose(hold_r[0]) && hold_r == 2'h1 |->
      vector_address_out_o == RST_VEC && !core_req_o ##1 hold_r == HOLD_EDGES)
      else $error("reset vector not held to the second edge");

   a_write_next: assert property (bus_wr && hit_base |=> base_r == $past(wr_base[BASE_W-1:0])
      ##1 (holding || vector_address_out_o[VA_W-1:LOW_W] == $past(base_r) || $past(win_ok)))
      else $error("base write not used the next cycle");

   a_irq_level: assert property (1'b1 |=> irq_o == |($past(stat_r) & $past(mask_r)))
      else $error("interrupt line does not follow masked status");

   a_set_wins: assert property (|ev |=> (stat_r & $past(ev)) == $past(ev))
      else $error("status event lost against a clear");

   a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a single cycle after request");

   a_reset_regs: assert property (hold_r == 2'h1 |-> prio_r == '0 && sel0_r == '0 && sel1_r == '0
      && base_r == BASE_RST[BASE_W-1:0] && stat_r == '0 && mask_r == '0)
      else $error("registers not at defaults after reset");

   a_hold_vec: assert property (holding |=> !core_req_o && vector_address_out_o == RST_VEC)
      else $error("reset vector dropped before the second edge");

   a_idle_out: assert property (!win_ok && !holding |=> !core_req_o
      && vector_address_out_o == {$past(base_r), LOW_W'(0)})
      else $error("idle vector does not show the base");

   a_off_silent: assert property ((prio_r[PIT2_PRIO_LSB +: CODE_W] != PRIO_OFF || !p_wins)
      && (prio_r[ADC_PRIO_LSB +: CODE_W] != PRIO_OFF || !a_wins))
      else $error("disabled source took part in arbitration");

   a_read_zero: assert property (wb_dat_o[DATA_W-1:REG_W] == '0 && (wb_ack_o || wb_dat_o == '0))
      else $error("read data outside the register word or ack cycle");

   a_clear_one: assert property (bus_wr && hit_stat |=>
      (stat_r & $past(wr_stat[ST_W-1:0]) & ~$past(ev)) == '0)
      else $error("status write one did not clear");

endmodule : vbfi_top

/* File: verif/vbfi_core_model.sv */
// processor core stand-in that takes presented vectors
`timescale 1ns/100ps
module vbfi_core_model (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic core_req_i,
   input  wire logic slow_i,
   output logic      core_ack_o
);
   logic [1:0] wait_r;

   // slow mode holds off three cycles so late acceptance is seen too
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_r     <= 2'h0;
         core_ack_o <= 1'b0;
      end else if (core_req_i && !core_ack_o && (!slow_i || wait_r == 2'h3)) begin
         wait_r     <= 2'h0;
         core_ack_o <= 1'b1;
      end else begin
         wait_r     <= core_req_i ? wait_r + 2'h1 : 2'h0;
         core_ack_o <= 1'b0;
      end
   end
endmodule : vbfi_core_model

/* File: verif/tb.sv */
// self-checking bench for the vector base and fast interrupt slice
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
   import vbfi_pkg::*;
   localparam logic [VEC_W-1:0] ADC_V = 6'h10;
   localparam logic [VEC_W-1:0] PIT_V = 6'h11;
   localparam int               LIMIT = 20000;
   localparam logic [3:0]  RIDX [10] = '{IDX_PRIO, IDX_BASE, IDX_SEL0, IDX_TLO0, IDX_THI0,
                                         IDX_SEL1, IDX_TLO1, IDX_THI1, IDX_STAT, IDX_MASK};
   localparam logic [3:0]  WIDX [6]  = '{IDX_BASE, IDX_SEL0, IDX_THI0, IDX_SEL1, IDX_THI1, IDX_PRIO};
   localparam logic [15:0] WEXP [6]  = '{16'h3FFF, 16'h003F, 16'h001F, 16'h003F, 16'h001F, 16'h000F};
   logic              clk_i, rst_b_i, cyc, stb, we, ack, slow, ext_req, adc, pit, core_ack, core_req, irq;
   logic [ADR_W-1:0]  adr;
   logic [DATA_W-1:0] wdat, rdat;
   logic [3:0]        sel;
   logic [1:0]        ext_prio;
   logic [5:0]        ext_vec;
   logic [20:0]       va, t0, t1;
   logic [31:0]       rs, r;
   logic [15:0]       q, p;
   logic [13:0]       b;
   int                error_cnt, checked, cyc_cnt;

   vbfi_top #(.ADC_A_VEC(ADC_V), .PIT2_VEC(PIT_V), .BASE_HI_VAR(1'b1)) dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ext_req_i(ext_req), .ext_prio_i(ext_prio), .ext_vec_i(ext_vec), .adc_a_done_irq_i(adc),
      .interval_timer2_irq_i(pit), .core_ack_i(core_ack), .vector_address_out_o(va),
      .core_req_o(core_req), .irq_o(irq));
   vbfi_core_model core (.clk_i(clk_i), .rst_b_i(rst_b_i), .core_req_i(core_req), .slow_i(slow),
                         .core_ack_o(core_ack));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd

   // request flag above the table address; lower vector breaks ties
   function automatic logic [VA_W:0] exp_tab(input logic [13:0] bs, input logic [3:0] cd,
                                             input logic er, input logic [1:0] ep, input logic [5:0] ev);
      logic [1:0] c [3];
      logic [5:0] v [3];
      logic [1:0] bc;
      logic [5:0] bv;
      c  = '{cd[3:2], cd[1:0], er ? ep : 2'h0};
      v  = '{ADC_V, PIT_V, ev};
      bc = 2'h0;
      bv = 6'h00;
      for (int i = 0; i < 3; i++) begin
         if (c[i] > bc || (c[i] == bc && c[i] != 2'h0 && v[i] < bv)) begin
            bc = c[i];
            bv = v[i];
         end
      end
      return {bc != 2'h0, bs, bv, 1'b0};
   endfunction : exp_tab

   task automatic wb(input logic w, input logic [3:0] i, input logic [15:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {i, 2'b00};
      wdat <= {16'h0000, d};
      sel  <= 4'h3;
      // no local limit: only the bench timeout ends a hung access
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic rchk(input string nm, input logic [3:0] i, input logic [15:0] e);
      wb(1'b0, i, 16'h0000);
      `CHK(nm, e, q)
   endtask : rchk

   // the output reflects inputs one edge later; look three edges on
   task automatic chk_out(input string nm, input logic [VA_W:0] e);
      repeat (3) @(posedge clk_i);
      `CHK(nm, e, {core_req, va})
   endtask : chk_out

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == LIMIT) begin
         error_cnt++;
         conclude();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst_b_i, cyc, stb, we, slow, ext_req, adc, pit, adr, wdat, sel, ext_prio, ext_vec} = '0;
      rs = 32'h0000_BAD4;
      repeat (5) @(posedge clk_i);
      `CHK("vector in reset", 21'h00_4000, va)
      `CHK("request in reset", 1'b0, core_req)
      repeat (15) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK("vector after release", 21'h00_4000, va)
      for (int k = 0; k < 10; k++) rchk("reset value", RIDX[k], (k == 1) ? 16'h0080 : 16'h0000);
      for (int k = 0; k < 6; k++) begin
         wb(1'b1, WIDX[k], 16'hFFFF);
         rchk("reserved bits", WIDX[k], WEXP[k]);
      end
      wb(1'b1, 4'h3, 16'hFFFF);
      rchk("unmapped", 4'h3, 16'h0000);
      wb(1'b1, IDX_SEL0, 16'h003F);
      wb(1'b1, IDX_SEL1, 16'h003E);
      $display("test registers done");
      for (int k = 0; k < 40; k++) begin
         b = 14'(rnd());
         p = (k < 4) ? {12'h000, k[1:0], k[1:0]} : {12'h000, 4'(rnd())};
         r = (k < 4) ? (rnd() | 32'h0000_0003) : rnd();
         wb(1'b1, IDX_BASE, {2'b00, b});
         wb(1'b1, IDX_PRIO, p);
         @(posedge clk_i);
         slow     <= k[0];
         adc      <= r[0];
         pit      <= r[1];
         ext_req  <= r[2];
         ext_prio <= r[4:3];
         ext_vec  <= {2'b00, r[8:5]};
         chk_out("table vector", exp_tab(b, p[3:0] & {{2{r[0]}}, {2{r[1]}}}, r[2], r[4:3], {2'b00, r[8:5]}));
      end
      $display("test table done");
      t0 = 21'(rnd());
      t1 = 21'(rnd());
      wb(1'b1, IDX_TLO0, t0[15:0]);
      wb(1'b1, IDX_THI0, {11'h000, t0[20:16]});
      wb(1'b1, IDX_TLO1, t1[15:0]);
      wb(1'b1, IDX_THI1, {11'h000, t1[20:16]});
      wb(1'b1, IDX_PRIO, 16'h000F);
      wb(1'b1, IDX_SEL1, {10'h000, PIT_V});
      @(posedge clk_i);
      adc      <= 1'b1;
      pit      <= 1'b1;
      ext_req  <= 1'b1;
      ext_prio <= 2'h3;
      ext_vec  <= 6'h01;
      chk_out("fast one", {1'b1, t1});
      wb(1'b1, IDX_SEL0, {10'h000, ADC_V});
      chk_out("fast zero", {1'b1, t0});
      wb(1'b1, IDX_SEL0, {10'h000, PIT_V});
      wb(1'b1, IDX_SEL1, {10'h000, ADC_V});
      chk_out("fast swapped", {1'b1, t0});
      $display("test fast done");
      wb(1'b1, IDX_SEL0, {10'h000, ADC_V});
      wb(1'b1, IDX_SEL1, 16'h003E);
      @(posedge clk_i);
      adc     <= 1'b0;
      pit     <= 1'b0;
      ext_req <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b1, IDX_STAT, 16'h0007);
      wb(1'b1, IDX_MASK, 16'h0001);
      rchk("status cleared", IDX_STAT, 16'h0000);
      `CHK("irq idle", 1'b0, irq)
      @(posedge clk_i);
      adc <= 1'b1;
      repeat (8) @(posedge clk_i);
      adc <= 1'b0;
      repeat (4) @(posedge clk_i);
      rchk("status fast zero", IDX_STAT, 16'h0001);
      `CHK("irq raised", 1'b1, irq)
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, (k == 2) ? IDX_STAT : IDX_MASK, (k == 0) ? 16'h0000 : 16'h0001);
         repeat (2) @(posedge clk_i);
         `CHK("irq level", k == 1, irq)
      end
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, IDX_SEL1, (k == 0) ? {10'h000, PIT_V} : 16'h003E);
         @(posedge clk_i);
         pit <= 1'b1;
         repeat (8) @(posedge clk_i);
         pit <= 1'b0;
         repeat (4) @(posedge clk_i);
         rchk("status fast one or table", IDX_STAT, (k == 0) ? 16'h0002 : 16'h0006);
      end
      $display("test interrupt done");
      wb(1'b1, IDX_BASE, 16'h1234);
      wb(1'b1, IDX_PRIO, 16'h000F);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK("vector in second reset", 21'h00_4000, va)
      rst_b_i <= 1'b1;
      rchk("base after reset", IDX_BASE, 16'h0080);
      rchk("priority after reset", IDX_PRIO, 16'h0000);
      rchk("select after reset", IDX_SEL0, 16'h0000);
      $display("test second reset done");
      conclude();
   end
endmodule : tb
